// ===== rtl/acs_sequencer.v
// conversion sequencer for a successive approximation converter
// Notes on behaviour
// R1: software trigger: sc1 write starts unless channel off
// R2: hardware trigger selected: trigger event starts conversion
// R3: continuous mode restarts after each transfer
// R4: completion transfers result, sets flag, gated irq
// R5: 10-bit: high read blocks transfers until low read
// R6: blocked: restart, unless single compare-false terminates
// R7: software avoids reading results during single conversion
// R8: sc1 write aborts, restarts if channel not off
// R9: writes to sc2, config, compare values abort
// R10: reset or stop entry without async clock aborts
// R11: abort keeps results; reset clears them
// R12: idle until started; async clock only when active
// R13: sample, short or long, then approximate, then transfer
// R14: first conversion: 20/23/40/43 conv clocks plus 5 bus
// R15: async clock source may add 5 us start-up
// R16: later continuous: 17/20/37/40 conv clocks
// R17: exact continuous timing needs fast enough bus clock
// R18: compare: add two's complement, ge or lt by select
// R19: compare true stores difference; false stores nothing
// R20: wait mode: conversions continue, trigger, flag, irq
// R21: wait mode keeps bus, half and async clock sources
// R22: converter disabled in reset and with channel off
// R23: rising trigger edge; ignored while converting
// R24: trigger synchronised and edge detected in bus domain
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.vh"
module acs_sequencer #(
   parameter ASYNC_DIV = 4 // bus cycles per async clock tick
) (
   input wire clk_i, // bus clock
   input wire rst_i, // synchronous reset, active high
   input wire cyc_i, // wishbone cycle
   input wire stb_i, // wishbone strobe
   input wire we_i, // wishbone write
   input wire [4:0] adr_i, // byte address
   input wire [3:0] sel_i, // byte selects
   input wire [31:0] dat_i, // write data
   output reg [31:0] dat_o, // read data
   output reg ack_o, // wishbone acknowledge
   input wire hw_trigger_input_i, // asynchronous trigger pin
   input wire alternate_clock_i, // alternate clock tick, same domain
   input wire stop_i, // system in stop mode, same domain
   input wire [9:0] sar_data_i, // approximation result from analog core
   output reg irq_o, // completion interrupt
   output reg active_o, // conversion in progress
   output reg sample_o, // input connected for sampling
   output reg async_en_o // async clock generator enabled
);
   // longest start-up wait, rounded down to whole bus cycles
   localparam integer ASYNC_START_CYC =
      (`ACS_ASYNC_START_NS * 1000) / `ACS_CLK_PERIOD_PS;
   // sequencer states
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_START = 3'h1;
   localparam [2:0] ST_SAMPLE = 3'h2;
   localparam [2:0] ST_SAR = 3'h3;
   localparam [2:0] ST_XFER = 3'h4;

   // offset match, used by both read and write decoding
   function hit;
      input [4:0] a;
      input [4:0] ofs;
      begin
         hit = (a == ofs);
      end
   endfunction

   // software registers
   reg flag_r; // conversion complete flag
   reg ien_r; // complete_irq_enable
   reg cont_r; // continuous_enable
   reg [4:0] chan_r; // channel_select_field
   reg trg_r; // trigger_select_bit
   reg cmpen_r; // compare_enable_bit
   reg cmpgt_r; // compare_greater_select
   reg [7:0] cfg_r; // config_reg
   reg [7:0] rh_r; // result_high_reg
   reg [7:0] rl_r; // result_low_reg
   reg [7:0] cvh_r; // compare_value_high
   reg [7:0] cvl_r; // compare_value_low
   reg block_r; // transfer blocking active
   // sequencer state
   reg [2:0] st_r;
   reg [4:0] cnt_r; // conversion clock count within phase
   reg [10:0] warm_r; // async start-up counter
   reg half_r; // bus clock halved
   reg [2:0] div_r; // conversion clock divider
   reg [15:0] atk_r; // async tick counter
   reg [2:0] trg_sync_r; // trigger synchroniser and edge history
   reg stop_d_r; // stop level delayed for entry detect

   // decoded fields
   wire [1:0] iclk = cfg_r[`ACS_CFG_CLK_HI:`ACS_CFG_CLK_LO];
   wire [1:0] divsel = cfg_r[`ACS_CFG_DIV_HI:`ACS_CFG_DIV_LO];
   wire lsmp = cfg_r[`ACS_CFG_LSMP];
   wire mode10 = (cfg_r[`ACS_CFG_MODE_HI:`ACS_CFG_MODE_LO] == `ACS_MODE_10);
   wire chan_off = (chan_r == `ACS_CHAN_OFF);

   // bus access strobes
   wire acc = cyc_i & stb_i & ~ack_o;
   wire wr = acc & we_i & sel_i[0];
   wire rd = acc & ~we_i;
   wire wr_sc1 = wr & hit(adr_i, `ACS_OFS_SC1);
   wire wr_mode = wr & (hit(adr_i, `ACS_OFS_SC2) | hit(adr_i, `ACS_OFS_CFG)
                 | hit(adr_i, `ACS_OFS_CVH) | hit(adr_i, `ACS_OFS_CVL));
   wire rd_rh = rd & hit(adr_i, `ACS_OFS_RH);
   wire rd_rl = rd & hit(adr_i, `ACS_OFS_RL);

   // trigger rising edge after two synchroniser stages
   wire trg_edge = trg_sync_r[1] & ~trg_sync_r[2]; // R24
   // stop entry with a synchronous conversion clock
   wire stop_abort = stop_i & ~stop_d_r & (iclk != `ACS_ICLK_ASYNC); // R10

   // async clock runs only while converting from it
   wire async_on = (st_r != ST_IDLE) & (iclk == `ACS_ICLK_ASYNC); // R12
   wire async_ready = (warm_r == 11'h000);
   wire async_tick = async_on & async_ready &
      (atk_r == ASYNC_DIV[15:0] - 16'h0001); // R15

   // source tick before division
   reg src_tick;
   always @* begin
      case (iclk)
         `ACS_ICLK_BUS: src_tick = 1'b1;
         `ACS_ICLK_HALF: src_tick = half_r;
         `ACS_ICLK_ALT: src_tick = alternate_clock_i;
         default: src_tick = async_tick;
      endcase
   end
   // divide by 1, 2, 4 or 8
   wire [2:0] div_mask = (3'h1 << divsel) - 3'h1;
   wire conversion_clock = src_tick & ((div_r & div_mask) == div_mask); // R21

   // sample length and approximation length
   wire [4:0] samp_len = lsmp ? `ACS_SAMP_LONG : `ACS_SAMP_SHORT; // R13
   wire [4:0] sar_len = mode10 ? `ACS_SAR_10 : `ACS_SAR_8; // R16

   // conversion result and compare arithmetic
   wire [9:0] res = mode10 ? sar_data_i : {2'h0, sar_data_i[9:2]};
   wire [9:0] cv = mode10 ? {cvh_r[1:0], cvl_r} : {2'h0, cvl_r};
   wire [10:0] diff = {1'b0, res} + {1'b0, ~cv} + 11'h001; // R18
   wire ge = diff[10];
   wire cmp_ok = ~cmpen_r | (cmpgt_r ? ge : ~ge); // R18
   wire [9:0] store = cmpen_r ? diff[9:0] : res; // R19

   // hardware trigger start, only from idle
   wire hw_start = trg_r & trg_edge & ~chan_off & (st_r == ST_IDLE); // R23

   // clock helpers: halved bus clock, divider, async generator
   always @(posedge clk_i) begin
      if (rst_i) begin
         half_r <= 1'b0;
         div_r <= 3'h0;
         atk_r <= 16'h0000;
         warm_r <= ASYNC_START_CYC[10:0];
      end else begin
         half_r <= ~half_r;
         // divider restarts with each start from idle
         if (st_r == ST_IDLE)
            div_r <= 3'h0;
         else if (src_tick)
            div_r <= div_r + 3'h1;
         // async generator warms up on every start from idle
         if (!async_on) begin
            warm_r <= ASYNC_START_CYC[10:0];
            atk_r <= 16'h0000;
         end else if (!async_ready) begin
            warm_r <= warm_r - 11'h001; // R15
         end else if (async_tick) begin
            atk_r <= 16'h0000;
         end else begin
            atk_r <= atk_r + 16'h0001;
         end
      end
   end

   // trigger synchroniser and stop delay
   always @(posedge clk_i) begin
      if (rst_i) begin
         trg_sync_r <= 3'h0;
         stop_d_r <= 1'b0;
      end else begin
         trg_sync_r <= {trg_sync_r[1:0], hw_trigger_input_i}; // R24
         stop_d_r <= stop_i;
      end
   end

   // wishbone slave and register writes
   always @(posedge clk_i) begin
      if (rst_i) begin
         ack_o <= 1'b0;
         dat_o <= 32'h0000_0000;
         ien_r <= 1'b0;
         cont_r <= 1'b0;
         chan_r <= `ACS_CHAN_OFF; // R22
         trg_r <= 1'b0;
         cmpen_r <= 1'b0;
         cmpgt_r <= 1'b0;
         cfg_r <= 8'h00;
         cvh_r <= 8'h00;
         cvl_r <= 8'h00;
      end else begin
         ack_o <= acc;
         // register read mux, unmapped offsets read zero
         if (rd) begin
            dat_o <= 32'h0000_0000;
            if (hit(adr_i, `ACS_OFS_SC1))
               dat_o[7:0] <= {flag_r, ien_r, cont_r, chan_r};
            if (hit(adr_i, `ACS_OFS_SC2))
               dat_o[7:0] <= {st_r != ST_IDLE, trg_r, cmpen_r, cmpgt_r, 4'h0};
            if (hit(adr_i, `ACS_OFS_CFG))
               dat_o[7:0] <= cfg_r;
            if (rd_rh)
               dat_o[7:0] <= rh_r;
            if (rd_rl)
               dat_o[7:0] <= rl_r;
            if (hit(adr_i, `ACS_OFS_CVH))
               dat_o[7:0] <= cvh_r;
            if (hit(adr_i, `ACS_OFS_CVL))
               dat_o[7:0] <= cvl_r;
         end
         // writes; flag bit of sc1 and active bit of sc2 are read-only
         if (wr_sc1) begin
            ien_r <= dat_i[`ACS_SC1_IEN];
            cont_r <= dat_i[`ACS_SC1_CONT];
            chan_r <= dat_i[`ACS_SC1_CHAN_HI:`ACS_SC1_CHAN_LO];
         end
         if (wr & hit(adr_i, `ACS_OFS_SC2)) begin
            trg_r <= dat_i[`ACS_SC2_TRG];
            cmpen_r <= dat_i[`ACS_SC2_CMPEN];
            cmpgt_r <= dat_i[`ACS_SC2_CMPGT];
         end
         if (wr & hit(adr_i, `ACS_OFS_CFG))
            cfg_r <= dat_i[7:0];
         if (wr & hit(adr_i, `ACS_OFS_CVH))
            cvh_r <= dat_i[7:0];
         if (wr & hit(adr_i, `ACS_OFS_CVL))
            cvl_r <= dat_i[7:0];
      end
   end

   // sequencer, result transfer and blocking
   always @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= ST_IDLE; // R10
         cnt_r <= 5'h00;
         flag_r <= 1'b0;
         block_r <= 1'b0;
         rh_r <= 8'h00; // R11
         rl_r <= 8'h00;
      end else begin
         // low read releases blocking and clears the flag
         if (rd_rl) begin
            block_r <= 1'b0;
            flag_r <= 1'b0;
         end
         // high read in 10-bit mode blocks transfers
         if (rd_rh & mode10)
            block_r <= 1'b1; // R5
         if (wr_sc1)
            flag_r <= 1'b0;
         if (wr_sc1) begin
            // abort, then software start if channel enabled
            cnt_r <= 5'h00;
            if (dat_i[`ACS_SC1_CHAN_HI:`ACS_SC1_CHAN_LO] != `ACS_CHAN_OFF && !trg_r) // R8
               st_r <= ST_START; // R1
            else
               st_r <= ST_IDLE; // R22
         end else if (wr_mode || stop_abort) begin
            // mode change or stop entry abort; results kept
            st_r <= ST_IDLE; // R9 R11
            cnt_r <= 5'h00;
         end else begin
            case (st_r)
               ST_IDLE: begin
                  cnt_r <= 5'h00;
                  if (hw_start)
                     st_r <= ST_START; // R2
               end
               ST_START: begin
                  // start-up of a single or first conversion
                  if (conversion_clock) begin
                     if (cnt_r == `ACS_STARTUP_CYC - 5'h01) begin
                        cnt_r <= 5'h00;
                        st_r <= ST_SAMPLE; // R14
                     end else begin
                        cnt_r <= cnt_r + 5'h01;
                     end
                  end
               end
               ST_SAMPLE: begin
                  if (conversion_clock) begin
                     if (cnt_r == samp_len - 5'h01) begin
                        cnt_r <= 5'h00;
                        st_r <= ST_SAR; // R13
                     end else begin
                        cnt_r <= cnt_r + 5'h01;
                     end
                  end
               end
               ST_SAR: begin
                  if (conversion_clock) begin
                     if (cnt_r == sar_len - 5'h01) begin
                        cnt_r <= 5'h00;
                        st_r <= ST_XFER;
                     end else begin
                        cnt_r <= cnt_r + 5'h01;
                     end
                  end
               end
               ST_XFER: begin
                  cnt_r <= 5'h00;
                  if (!cmp_ok) begin
                     // compare false: nothing stored, no flag
                     st_r <= cont_r ? ST_SAMPLE : ST_IDLE; // R19 R6
                  end else if (block_r && !rd_rl) begin
                     // blocked: result lost, convert again
                     st_r <= ST_SAMPLE; // R6 R5
                  end else begin
                     rh_r <= mode10 ? {6'h00, store[9:8]} : 8'h00; // R4
                     rl_r <= store[7:0];
                     flag_r <= 1'b1; // R4 R20
                     st_r <= cont_r ? ST_SAMPLE : ST_IDLE; // R3 R17
                  end
               end
               default: st_r <= ST_IDLE;
            endcase
         end
      end
   end

   // registered outputs
   always @(posedge clk_i) begin
      if (rst_i) begin
         irq_o <= 1'b0;
         active_o <= 1'b0;
         sample_o <= 1'b0;
         async_en_o <= 1'b0;
      end else begin
         irq_o <= flag_r & ien_r; // R4 R20
         active_o <= (st_r != ST_IDLE);
         sample_o <= (st_r == ST_SAMPLE); // R13
         async_en_o <= async_on; // R12
      end
   end
endmodule // acs_sequencer
`default_nettype wire

// ===== rtl/acs_defs.vh
// constants for the conversion sequencer: offsets, fields, timing
`ifndef ACS_DEFS_VH
`define ACS_DEFS_VH
// register byte offsets on the bus
`define ACS_OFS_SC1 5'h00
`define ACS_OFS_SC2 5'h04
`define ACS_OFS_CFG 5'h08
`define ACS_OFS_RH 5'h0c
`define ACS_OFS_RL 5'h10
`define ACS_OFS_CVH 5'h14
`define ACS_OFS_CVL 5'h18
// status_control_one_reg fields
`define ACS_SC1_FLAG 7
`define ACS_SC1_IEN 6
`define ACS_SC1_CONT 5
`define ACS_CHAN_OFF 5'h1f
`define ACS_SC1_CHAN_HI 4
`define ACS_SC1_CHAN_LO 0
// status_control_two_reg fields
`define ACS_SC2_ACT 7
`define ACS_SC2_TRG 6
`define ACS_SC2_CMPEN 5
`define ACS_SC2_CMPGT 4
// config_reg fields
`define ACS_CFG_LP 7
`define ACS_CFG_DIV_HI 6
`define ACS_CFG_DIV_LO 5
`define ACS_CFG_LSMP 4
`define ACS_CFG_MODE_HI 3
`define ACS_CFG_MODE_LO 2
`define ACS_CFG_CLK_HI 1
`define ACS_CFG_CLK_LO 0
`define ACS_MODE_10 2'h2
`define ACS_ICLK_BUS 2'h0
`define ACS_ICLK_HALF 2'h1
`define ACS_ICLK_ALT 2'h2
`define ACS_ICLK_ASYNC 2'h3
// phase lengths in conversion clock cycles
`define ACS_STARTUP_CYC 5'h03
`define ACS_SAMP_SHORT 5'h03
`define ACS_SAMP_LONG 5'h17
`define ACS_SAR_8 5'h0e
`define ACS_SAR_10 5'h11
// async clock start-up time and bus clock period
`define ACS_ASYNC_START_NS 5000
`define ACS_CLK_PERIOD_PS 4000
`endif

// ===== sim/acs_assertions.sv
// port checker for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
module acs_checker (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic cyc_i,
   input wire logic stb_i,
   input wire logic we_i,
   input wire logic [4:0] adr_i,
   input wire logic [3:0] sel_i,
   input wire logic [31:0] dat_o,
   input wire logic ack_o,
   input wire logic irq_o,
   input wire logic active_o,
   input wire logic sample_o,
   input wire logic async_en_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   logic req; // access taken at this edge
   logic wr0; // byte write taken at this edge
   assign req = cyc_i & stb_i & ~ack_o;
   assign wr0 = req & we_i & sel_i[0];
   logic mode_wr; // write to a mode register taken at this edge
   assign mode_wr = wr0 && (adr_i == 5'h04 || adr_i == 5'h08 || adr_i == 5'h14
      || adr_i == 5'h18);
   a_ack_after_req: assert property (req |=> ack_o)
      else $error("no ack after request");
   a_ack_one_cycle: assert property (ack_o |=> !ack_o)
      else $error("ack longer than one cycle");
   a_ack_has_cause: assert property ($rose(ack_o) |-> $past(req))
      else $error("ack without request");
   a_unmapped_zero: assert property (req && !we_i && adr_i > 5'h18 |=> dat_o == 32'h0)
      else $error("unmapped read not zero");
   a_upper_bits_zero: assert property (ack_o |-> dat_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_mode_write_aborts: assert property (mode_wr && active_o |=> ##[0:2] !active_o)
      else $error("mode write did not abort");
   a_sc1_clears_irq: assert property (wr0 && adr_i == 5'h00 |=> ##[1:2] !irq_o)
      else $error("irq survives control write");
   a_async_only_active: assert property (async_en_o |-> active_o || $past(active_o))
      else $error("async clock on while idle");
   a_sample_in_conv: assert property (sample_o |-> active_o || $past(active_o))
      else $error("sampling while idle");
   c_conv_done: cover property ($fell(active_o));
   c_irq_seen: cover property ($rose(irq_o));
   c_async_seen: cover property ($rose(async_en_o));
endmodule // acs_checker
bind acs_sequencer acs_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
   .irq_o(irq_o), .active_o(active_o), .sample_o(sample_o), .async_en_o(async_en_o));
`default_nettype wire

// ===== sim/acs_sequencer_tb_top.sv
// self-checking bench for the conversion sequencer
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.vh"
module acs_sequencer_tb_top;
   logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0, hw_trig = 0, stop_i = 0;
   logic [4:0] adr_i = 0;
   logic [3:0] sel_i = 0;
   logic [31:0] dat_i = 0, dat_o;
   logic [9:0] sar_i = 0;
   logic ack_o, irq_o, active_o, sample_o, async_en_o;
   logic [7:0] q, lo, c;
   logic [8:0] m;
   int num_errors = 0, checks = 0, ticks = 0, n, k;
   logic [7:0] cfg_t [6] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h01, 8'h02}; // configs
   int bud_t [6] = '{25, 28, 45, 48, 45, 25}; // worst-case bus cycles per config
   logic [4:0] ab_a [5] = '{`ACS_OFS_SC2, `ACS_OFS_CFG, `ACS_OFS_CVH, `ACS_OFS_CVL,
      `ACS_OFS_SC1};
   acs_sequencer #(.ASYNC_DIV(2)) uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
      .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
      .dat_o(dat_o), .ack_o(ack_o), .hw_trigger_input_i(hw_trig), .alternate_clock_i(1'b1),
      .stop_i(stop_i), .sar_data_i(sar_i), .irq_o(irq_o), .active_o(active_o),
      .sample_o(sample_o), .async_en_o(async_en_o));
   initial forever #2 clk_i = ~clk_i;
   // hang guard
   always @(posedge clk_i) begin
      ticks++;
      if (ticks == 20000) begin
         num_errors++;
         wrap_up;
      end
   end
   task wrap_up;
      if (num_errors == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task chk(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected at %0t: got %h want %h", $time, g, e);
      end
   endtask
   // one classic bus access, read byte left in q
   task wb(input logic w, input logic [4:0] a, input logic [7:0] d);
      @(posedge clk_i);
      cyc_i <= 1;
      stb_i <= 1;
      we_i <= w;
      adr_i <= a;
      sel_i <= 4'hf;
      dat_i <= {24'h0, d};
      do @(posedge clk_i); while (ack_o !== 1'b1);
      q = dat_o[7:0];
      cyc_i <= 0;
      stb_i <= 0;
   endtask
   // waits for the converter to go idle, cycles counted in n
   task idle(input int lim);
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while ((active_o !== 1'b0 || n < 3) && n < lim);
   endtask
   // compare model: bit 8 condition, low bits difference
   function automatic logic [8:0] cmp_model(input logic gt, input logic [7:0] r,
      input logic [7:0] v);
      cmp_model = {(r >= v) == gt, 8'(r - v)};
   endfunction
   initial begin
      void'($urandom(54227));
      repeat (12) @(posedge clk_i);
      rst_i <= 0;
      wb(0, `ACS_OFS_SC1, 0); chk(q, 8'h1f);
      wb(0, `ACS_OFS_RL, 0); chk(q, 8'h00);
      wb(0, 5'h1c, 0); chk(q, 8'h00);
      chk(active_o, 0);
      // single conversions over modes, sample lengths and clock sources
      for (k = 0; k < 6; k++) begin
         sar_i <= 10'($urandom);
         wb(1, `ACS_OFS_CFG, cfg_t[k]);
         wb(1, `ACS_OFS_SC1, 8'h41);
         idle(300);
         chk(n <= bud_t[k], 1);
         chk(irq_o, 1);
         wb(0, `ACS_OFS_SC1, 0); chk(q, 8'hc1);
         wb(0, `ACS_OFS_RH, 0); chk(q, cfg_t[k][3] ? {6'h0, sar_i[9:8]} : 8'h0);
         wb(0, `ACS_OFS_RL, 0); chk(q, cfg_t[k][3] ? sar_i[7:0] : sar_i[9:2]);
      end
      // high read during a 10-bit conversion blocks its transfer
      wb(1, `ACS_OFS_CFG, 8'h08);
      wb(1, `ACS_OFS_SC1, 8'h01);
      wb(0, `ACS_OFS_RH, 0);
      repeat (25) @(posedge clk_i);
      chk(active_o, 1);
      wb(0, `ACS_OFS_SC1, 0); chk(q, 8'h01);
      sar_i <= 10'($urandom);
      wb(0, `ACS_OFS_RL, 0);
      idle(300);
      wb(0, `ACS_OFS_SC1, 0); chk(q, 8'h81);
      wb(0, `ACS_OFS_RH, 0); chk(q, {6'h0, sar_i[9:8]});
      wb(0, `ACS_OFS_RL, 0); chk(q, sar_i[7:0]);
      // automatic compare, both directions
      wb(1, `ACS_OFS_CFG, 8'h00);
      for (k = 0; k < 8; k++) begin
         sar_i <= 10'($urandom);
         c = 8'($urandom);
         wb(1, `ACS_OFS_SC2, {3'b001, k[0], 4'h0});
         wb(1, `ACS_OFS_CVL, c);
         wb(0, `ACS_OFS_RL, 0);
         lo = q;
         wb(1, `ACS_OFS_SC1, 8'h01);
         idle(300);
         m = cmp_model(k[0], sar_i[9:2], c);
         wb(0, `ACS_OFS_SC1, 0); chk(q[7], m[8]);
         wb(0, `ACS_OFS_RL, 0); chk(q, m[8] ? m[7:0] : lo);
      end
      // aborts by writes and by stop entry keep the old result
      wb(1, `ACS_OFS_SC2, 8'h00);
      for (k = 0; k < 6; k++) begin
         wb(0, `ACS_OFS_RL, 0);
         lo = q;
         sar_i <= 10'($urandom);
         wb(1, `ACS_OFS_SC1, 8'h01);
         repeat (4) @(posedge clk_i);
         if (k == 5)
            stop_i <= 1;
         else
            wb(1, ab_a[k], (k == 4) ? 8'h1f : 8'h00);
         repeat (3) @(posedge clk_i);
         chk(active_o, 0);
         stop_i <= 0;
         wb(0, `ACS_OFS_SC1, 0); chk(q[7], 0);
         wb(0, `ACS_OFS_RL, 0); chk(q, lo);
      end
      // continuous mode keeps converting
      wb(1, `ACS_OFS_SC1, 8'h21);
      repeat (60) @(posedge clk_i);
      chk(active_o, 1);
      wb(0, `ACS_OFS_SC1, 0); chk(q, 8'ha1);
      wb(0, `ACS_OFS_RL, 0); chk(q, sar_i[9:2]);
      // hardware trigger: rising edge starts, edges while busy ignored
      wb(1, `ACS_OFS_SC2, 8'h40);
      wb(1, `ACS_OFS_SC1, 8'h01);
      hw_trig <= 1;
      repeat (8) @(posedge clk_i);
      chk(active_o, 1);
      hw_trig <= 0;
      repeat (2) @(posedge clk_i);
      hw_trig <= 1;
      idle(300);
      repeat (8) @(posedge clk_i);
      chk(active_o, 0);
      hw_trig <= 0;
      // internal async clock only runs during a conversion
      wb(1, `ACS_OFS_SC2, 8'h00);
      wb(1, `ACS_OFS_CFG, 8'h03);
      chk(async_en_o, 0);
      wb(1, `ACS_OFS_SC1, 8'h01);
      repeat (3) @(posedge clk_i);
      chk(async_en_o, 1);
      idle(2000);
      chk(n <= 1295, 1);
      @(posedge clk_i);
      chk(async_en_o, 0);
      // reset in mid-conversion stops the converter and clears results
      wb(1, `ACS_OFS_SC1, 8'h01);
      repeat (4) @(posedge clk_i);
      rst_i <= 1;
      repeat (12) @(posedge clk_i);
      rst_i <= 0;
      chk(active_o, 0);
      wb(0, `ACS_OFS_RL, 0); chk(q, 8'h00);
      wb(0, `ACS_OFS_SC1, 0); chk(q, 8'h1f);
      wrap_up;
   end
endmodule // acs_sequencer_tb_top
`default_nettype wire
